// ==== rtl/prsel_regs.svh ====
`ifndef PRSEL_REGS_SVH
`define PRSEL_REGS_SVH
// register indices as printed; byte address is four times the index
`define PRSEL_IDX_RXCTL 12'h108
`define PRSEL_IDX_RXSEL 12'h109
`define PRSEL_IDX_HOLD 12'h10a
`define PRSEL_IDX_FLOCK 12'h10b
`define PRSEL_IDX_STAT 12'h10c
`define PRSEL_ADDR_W 14
// field positions
`define PRSEL_RXCTL_DIFF 5
`define PRSEL_RXSEL_NEG 0
`define PRSEL_HOLD_EN 3
`define PRSEL_MODE_PIN 2
`define PRSEL_MODE_MAN 1
`define PRSEL_FLOCK_EN 7
// reset values
`define PRSEL_RST_RXCTL 8'h00
`define PRSEL_RST_RXSEL 8'h00
`define PRSEL_RST_HOLD 8'h00
`define PRSEL_RST_FLOCK 8'h00
// mode codes
`define PRSEL_MODE_NONREV 3'h0
`define PRSEL_MODE_REVERT 3'h1
`define PRSEL_MODE_PRI 3'h2
`define PRSEL_MODE_SEC 3'h3
`endif

// ==== rtl/prsel_pkg.sv ====
package prsel_pkg;
  // which reference drives the loop
  typedef enum logic {PRSEL_PRI, PRSEL_SEC} prsel_ref_t;
  // state of the automatic switchover
  typedef enum logic [1:0] {ST_ON_PRI, ST_ON_SEC, ST_HOLD} prsel_state_t;
endpackage : prsel_pkg

// ==== rtl/prsel_ctrl.sv ====
`timescale 1ns/100ps
`include "prsel_regs.svh"
// Notes on behaviour
// RQ1: negative pin choice only when single-ended
// RQ2: holdover on clock failure forces midsupply tuning
// RQ3: holdover cleared tristates the charge pump
// RQ4: 3-bit mode, 010 primary, 011 secondary
// RQ5: 000 stays secondary, 001 reverts to primary
// RQ6: mode top bit follows pin, low primary
// RQ7: pin high selects secondary reference
// RQ8: fast-lock bit 7 enables fast lock
// RQ9: 7-bit fast-lock charge pump current
// RQ10: differential bit 1 differential, 0 single-ended
// RQ11: select pin synchronized before use
module prsel_ctrl (
  input wire logic pclk, // 25 MHz bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [15:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic ref_sel_pin, // board select pin, asynchronous
  input wire logic pri_valid, // primary reference present
  input wire logic sec_valid, // secondary reference present
  input wire logic fb_valid, // feedback clock present
  output logic use_secondary_r, // 1 = secondary reference selected
  output logic pri_diff_r, // primary receiver differential
  output logic pri_neg_pin_r, // primary single-ended uses negative pin
  output logic tune_mid_r, // force tuning voltage to half supply
  output logic cp_tristate_r, // charge pump output high impedance
  output logic fast_lock_r, // fast lock enabled
  output logic [6:0] fl_cp_current_r // fast lock pump current, 0.5 ua steps
);
  logic [7:0] rxctl_r;
  logic [7:0] rxsel_r;
  logic [7:0] hold_r;
  logic [7:0] flock_r;
  logic [1:0] pin_sync_r;
  logic [2:0] valid_s1_r;
  logic [2:0] valid_s2_r;
  prsel_pkg::prsel_state_t state_r;
  prsel_pkg::prsel_state_t state_nxt;
  logic [`PRSEL_ADDR_W-3:0] idx;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [2:0] mode;
  logic fail;
  logic sec_nxt;

  assign idx = paddr[`PRSEL_ADDR_W-1:2];
  assign hit = (idx >= `PRSEL_IDX_RXCTL) && (idx <= `PRSEL_IDX_STAT)
               && (paddr[1:0] == 2'h0)
               && ((paddr >> `PRSEL_ADDR_W) == 16'h0); // no aliasing
  assign wr_en = psel && penable && pwrite && pready && hit;
  assign rd_en = psel && !penable && !pwrite;
  assign mode = hold_r[2:0];

  // apb answers in the first access cycle, one cycle after setup, so pready rises there
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end

  // register writes; status is read-only and ignores writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxctl_r <= `PRSEL_RST_RXCTL; // see RQ10
      rxsel_r <= `PRSEL_RST_RXSEL;
      hold_r <= `PRSEL_RST_HOLD; // see RQ4
      flock_r <= `PRSEL_RST_FLOCK;
    end else if (wr_en) begin
      case (idx)
        `PRSEL_IDX_RXCTL: rxctl_r <= pwdata[7:0];
        `PRSEL_IDX_RXSEL: rxsel_r <= pwdata[7:0];
        `PRSEL_IDX_HOLD: hold_r <= {4'h0, pwdata[3:0]};
        `PRSEL_IDX_FLOCK: flock_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // read data captured in setup so it comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      case (idx)
        `PRSEL_IDX_RXCTL: prdata <= {24'h0, rxctl_r};
        `PRSEL_IDX_RXSEL: prdata <= {24'h0, rxsel_r};
        `PRSEL_IDX_HOLD: prdata <= {24'h0, hold_r};
        `PRSEL_IDX_FLOCK: prdata <= {24'h0, flock_r};
        `PRSEL_IDX_STAT: prdata <= {26'h0, tune_mid_r, use_secondary_r,
                                    pin_sync_r[1], valid_s2_r};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // two-flop synchronisers; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r <= 2'h0;
      valid_s1_r <= 3'h0;
      valid_s2_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], ref_sel_pin}; // see RQ11
      valid_s1_r <= {fb_valid, sec_valid, pri_valid};
      valid_s2_r <= valid_s1_r;
    end
  end

  // valid_s2_r: [0] primary, [1] secondary, [2] feedback
  assign fail = !valid_s2_r[2] ||
                (use_secondary_r ? !valid_s2_r[1] : !valid_s2_r[0]);

  // automatic switchover; manual and pin modes bypass the state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      prsel_pkg::ST_ON_PRI: begin
        if (!valid_s2_r[0] && valid_s2_r[1]) begin
          state_nxt = prsel_pkg::ST_ON_SEC;
        end
      end
      prsel_pkg::ST_ON_SEC: begin
        if (mode == `PRSEL_MODE_REVERT && valid_s2_r[0]) begin
          state_nxt = prsel_pkg::ST_ON_PRI; // see RQ5
        end else if (!valid_s2_r[1] && valid_s2_r[0]) begin
          state_nxt = prsel_pkg::ST_ON_PRI;
        end
      end
      prsel_pkg::ST_HOLD: state_nxt = prsel_pkg::ST_ON_PRI;
      default: state_nxt = prsel_pkg::ST_ON_PRI;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= prsel_pkg::ST_ON_PRI;
    end else if (mode[`PRSEL_MODE_PIN] || mode[`PRSEL_MODE_MAN]) begin
      state_r <= use_secondary_r ? prsel_pkg::ST_ON_SEC
                                 : prsel_pkg::ST_ON_PRI;
    end else begin
      state_r <= state_nxt; // see RQ5
    end
  end

  // selection by mode; pin mode ignores the low two bits
  always_comb begin
    if (mode[`PRSEL_MODE_PIN]) begin
      sec_nxt = pin_sync_r[1]; // see RQ6 see RQ7
    end else if (mode == `PRSEL_MODE_PRI) begin
      sec_nxt = 1'b0; // see RQ4
    end else if (mode == `PRSEL_MODE_SEC) begin
      sec_nxt = 1'b1; // see RQ4
    end else begin
      sec_nxt = (state_nxt == prsel_pkg::ST_ON_SEC);
    end
  end

  // loop outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_secondary_r <= 1'b0;
      pri_diff_r <= 1'b0;
      pri_neg_pin_r <= 1'b0;
      tune_mid_r <= 1'b0;
      cp_tristate_r <= 1'b1;
      fast_lock_r <= 1'b0;
      fl_cp_current_r <= 7'h0;
    end else begin
      use_secondary_r <= sec_nxt;
      pri_diff_r <= rxctl_r[`PRSEL_RXCTL_DIFF]; // see RQ10
      // negative pin has no meaning in differential mode
      pri_neg_pin_r <= !rxctl_r[`PRSEL_RXCTL_DIFF] &&
                       rxsel_r[`PRSEL_RXSEL_NEG]; // see RQ1
      tune_mid_r <= hold_r[`PRSEL_HOLD_EN] && fail; // see RQ2
      cp_tristate_r <= !hold_r[`PRSEL_HOLD_EN]; // see RQ3
      fast_lock_r <= flock_r[`PRSEL_FLOCK_EN]; // see RQ8
      fl_cp_current_r <= flock_r[6:0]; // see RQ9
    end
  end

  // checks
  property p_neg_pin;
    @(posedge pclk) disable iff (!presetn)
      rxctl_r[`PRSEL_RXCTL_DIFF] |=> !pri_neg_pin_r;
  endproperty
  a_neg_pin: assert property (p_neg_pin) // see RQ1
    else $error("neg pin in diff");

  property p_hold_mid;
    @(posedge pclk) disable iff (!presetn)
      (hold_r[`PRSEL_HOLD_EN] && fail) |=> tune_mid_r;
  endproperty
  a_hold_mid: assert property (p_hold_mid) // see RQ2
    else $error("no midsupply");

  property p_tristate;
    @(posedge pclk) disable iff (!presetn)
      !hold_r[`PRSEL_HOLD_EN] |=> cp_tristate_r && !tune_mid_r;
  endproperty
  a_tristate: assert property (p_tristate) // see RQ3
    else $error("pump not hi-z");

  property p_force;
    @(posedge pclk) disable iff (!presetn)
      (mode == `PRSEL_MODE_PRI) |=> !use_secondary_r;
  endproperty
  a_force: assert property (p_force) // see RQ4
    else $error("forced pri lost");

  property p_force_sec;
    @(posedge pclk) disable iff (!presetn)
      (mode == `PRSEL_MODE_SEC) |=> use_secondary_r;
  endproperty
  a_force_sec: assert property (p_force_sec) // see RQ4
    else $error("forced sec lost");

  property p_nonrev;
    @(posedge pclk) disable iff (!presetn)
      (mode == `PRSEL_MODE_NONREV && use_secondary_r && valid_s2_r[1]
       && $stable(mode)) |=> use_secondary_r;
  endproperty
  a_nonrev: assert property (p_nonrev) // see RQ5
    else $error("reverted");

  sequence s_pin_high;
    (mode[`PRSEL_MODE_PIN] && ref_sel_pin) [*4];
  endsequence
  property p_pin;
    @(posedge pclk) disable iff (!presetn)
      s_pin_high |-> use_secondary_r;
  endproperty
  a_pin: assert property (p_pin) // see RQ7
    else $error("pin high not sec");

  property p_pin_low;
    @(posedge pclk) disable iff (!presetn)
      (mode[`PRSEL_MODE_PIN] && !ref_sel_pin) [*4] |-> !use_secondary_r;
  endproperty
  a_pin_low: assert property (p_pin_low) // see RQ6
    else $error("pin low not pri");

  property p_flock;
    @(posedge pclk) disable iff (!presetn)
      ##1 fast_lock_r == $past(flock_r[`PRSEL_FLOCK_EN])
      && fl_cp_current_r == $past(flock_r[6:0]);
  endproperty
  a_flock: assert property (p_flock) // see RQ8 see RQ9
    else $error("fast lock mismatch");

  property p_sync;
    @(posedge pclk) disable iff (!presetn)
      $rose(ref_sel_pin) && mode[`PRSEL_MODE_PIN] |=> !pin_sync_r[1];
  endproperty
  a_sync: assert property (p_sync) // see RQ11
    else $error("pin not delayed");

  // bus answer: ready in the access cycle only, one cycle long
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      s_setup |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready not one cycle after setup");

  property p_slverr;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !hit) |=> pslverr && pready;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped access without error");

  property p_revert;
    @(posedge pclk) disable iff (!presetn)
      (mode == `PRSEL_MODE_REVERT && $stable(mode) && use_secondary_r
       && valid_s2_r[0]) |=> !use_secondary_r;
  endproperty
  a_revert: assert property (p_revert) // see RQ5
    else $error("no revert to primary");

  // automatic modes leave a lost primary for a present secondary
  sequence s_pri_lost;
    !mode[`PRSEL_MODE_PIN] && !mode[`PRSEL_MODE_MAN] && $stable(mode)
    && !use_secondary_r && !valid_s2_r[0] && valid_s2_r[1];
  endsequence
  property p_switch;
    @(posedge pclk) disable iff (!presetn)
      s_pri_lost |=> use_secondary_r;
  endproperty
  a_switch: assert property (p_switch) // see RQ5
    else $error("no switch to secondary");

  property p_mid_cause;
    @(posedge pclk) disable iff (!presetn)
      !fail |=> !tune_mid_r;
  endproperty
  a_mid_cause: assert property (p_mid_cause) // see RQ2
    else $error("midsupply without failure");
endmodule : prsel_ctrl

// ==== testbench/prsel_pin_drv.sv ====
`timescale 1ns/100ps
// board logic holding the reference select pin
module prsel_pin_drv (
  input wire logic pclk, // device clock
  input wire logic want_sec, // bench asks for secondary
  output logic ref_sel_pin // select pin level
);
  // pin moves only just after an edge; the device syncs it anyway
  always_ff @(posedge pclk) begin
    ref_sel_pin <= want_sec;
  end
endmodule : prsel_pin_drv

// ==== testbench/test_pll1_ref_select_holdover_ctrl.sv ====
`timescale 1ns/100ps
module test_pll1_ref_select_holdover_ctrl;
  logic pclk, presetn, psel, penable, pwrite, want_sec, pin;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e, pv, sv, fv;
  logic use_sec, diff, neg, tmid, cptri, fl;
  logic [6:0] cur;
  int bad_count, n_compared;
  prsel_pin_drv u_pin (.pclk(pclk), .want_sec(want_sec), .ref_sel_pin(pin));
  prsel_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_sel_pin(pin), .pri_valid(pv), .sec_valid(sv), .fb_valid(fv),
    .use_secondary_r(use_sec), .pri_diff_r(diff), .pri_neg_pin_r(neg),
    .tune_mid_r(tmid), .cp_tristate_r(cptri), .fast_lock_r(fl),
    .fl_cp_current_r(cur));
  // clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task final_report;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; ready, error and read data taken at the same edge
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        $display("BAD %0t no ready", $time);
        final_report;
      end
      @(posedge pclk);
    end
    e = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // outputs after the sync and register stages have passed
  task out(input logic [5:0] f, input logic [6:0] c);
    repeat (4) @(posedge pclk);
    chk({19'h0, use_sec, diff, neg, tmid, cptri, fl, cur}, {19'h0, f, c});
  endtask : out
  task mode(input logic [2:0] m, input logic p, input logic s);
    want_sec <= p;
    apb(1'b1, 16'h0428, {29'h0, m});
    out({s, 5'b00010}, 7'h0);
  endtask : mode
  task t_reset;
    out(6'b000010, 7'h0);
    apb(1'b0, 16'h0428, 32'h0);
    chk(q, 32'h0);
  endtask : t_reset
  task t_rx;
    apb(1'b1, 16'h0424, 32'h1);
    out(6'b001010, 7'h0);
    apb(1'b1, 16'h0420, 32'h20);
    out(6'b010010, 7'h0);
    apb(1'b1, 16'h0420, 32'h0);
    apb(1'b1, 16'h0424, 32'h0);
  endtask : t_rx
  task t_fl;
    apb(1'b1, 16'h042c, 32'hff);
    out(6'b000011, 7'h7f);
    apb(1'b0, 16'h042c, 32'h0);
    chk(q, 32'hff);
    apb(1'b1, 16'h042c, 32'h3a);
    out(6'b000010, 7'h3a);
    apb(1'b1, 16'h042c, 32'h0);
  endtask : t_fl
  // forced and pin-driven codes, pin set against the forced choice
  task t_mode;
    mode(3'h2, 1'b1, 1'b0);
    mode(3'h3, 1'b0, 1'b1);
    mode(3'h4, 1'b1, 1'b1);
    mode(3'h7, 1'b0, 1'b0);
    mode(3'h6, 1'b1, 1'b1);
    mode(3'h5, 1'b0, 1'b0);
  endtask : t_mode
  task t_auto;
    apb(1'b1, 16'h0428, 32'h0);
    pv <= 1'b0;
    out(6'b100010, 7'h0);
    pv <= 1'b1;
    out(6'b100010, 7'h0);
    apb(1'b1, 16'h0428, 32'h1);
    out(6'b000010, 7'h0);
    pv <= 1'b0;
    out(6'b100010, 7'h0);
    pv <= 1'b1;
    out(6'b000010, 7'h0);
  endtask : t_auto
  task t_hold;
    apb(1'b1, 16'h0428, 32'h0b);
    out(6'b100000, 7'h0);
    fv <= 1'b0;
    out(6'b100100, 7'h0);
    apb(1'b0, 16'h0430, 32'h0);
    chk(q, 32'h33);
    fv <= 1'b1;
    sv <= 1'b0;
    out(6'b100100, 7'h0);
    apb(1'b1, 16'h0428, 32'h03);
    out(6'b100010, 7'h0);
    sv <= 1'b1;
    apb(1'b0, 16'h0434, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
  endtask : t_hold
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, want_sec} = 5'h0;
    {pv, sv, fv} = 3'h7;
    paddr = 16'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_rx;
    t_fl;
    t_mode;
    t_auto;
    t_hold;
    final_report;
  end
endmodule : test_pll1_ref_select_holdover_ctrl
